/* File: hw/sdsr_pkg.sv */
// shared constants of the dual tapped shift register
package sdsr_pkg;
    localparam int STAGES = 64;
    localparam int SEGMENT = 16;
    localparam int CHANNELS = 2;
    localparam int TAPS = 4;
    // bit index of the last stage of each 16-stage segment
    localparam int TAP16_POS = 15;
    localparam int TAP32_POS = 31;
    localparam int TAP48_POS = 47;
    localparam int TAP64_POS = 63;
    // bit index of the first stage of the second to fourth segment
    localparam int LOAD17_POS = 16;
    localparam int LOAD33_POS = 32;
    localparam int LOAD49_POS = 48;
    localparam int FIFO_DEPTH = 4;
    localparam logic [63:0] STAGE_RESET = 64'h0000_0000_0000_0000;
    localparam logic OE_N_RESET = 1'h1;
endpackage

/* File: hw/sdsr_edge_detect.sv */
// rising and falling edge pulses of a shift clock sampled on clk
`timescale 1ns/10ps
module sdsr_edge_detect
(
    // system
    input wire logic clk,
    input wire logic reset,
    // sampled level and its edges
    input wire logic level_in,
    output logic rise,
    output logic fall
);
    logic prev_r;

    // prev resets low so a clock held high at release counts as one edge
    always_ff @(posedge clk)
    begin
        if (reset)
            prev_r <= 1'h0;
        else
            prev_r <= level_in;
    end

    assign rise = level_in & ~prev_r;
    assign fall = ~level_in & prev_r;
endmodule

/* File: hw/sdsr_fifo.sv */
// small fifo with valid and ready on both sides
`timescale 1ns/10ps
module sdsr_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
)
(
    // system
    input wire logic clk,
    input wire logic reset,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LAST_C = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW:0] count_r;
    logic [PW:0] count_nxt;
    logic full_r;
    logic empty_r;
    logic push;
    logic pop;

    assign push = in_valid & ~full_r;
    assign pop = out_ready & ~empty_r;
    assign in_ready = ~full_r;
    assign out_valid = ~empty_r;
    assign out_data = mem_r[rd_ptr_r];

    always_comb
    begin
        count_nxt = count_r;
        if (push && !pop)
            count_nxt = count_r + (PW+1)'(1);
        else if (pop && !push)
            count_nxt = count_r - (PW+1)'(1);
    end

    always_ff @(posedge clk)
    begin
        if (push)
            mem_r[wr_ptr_r] <= in_data;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= (wr_ptr_r == LAST_C) ? '0 : wr_ptr_r + PW'(1);
            if (pop)
                rd_ptr_r <= (rd_ptr_r == LAST_C) ? '0 : rd_ptr_r + PW'(1);
        end
    end

    // flags registered so the top sees them straight from flops
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            count_r <= '0;
            full_r <= 1'h0;
            empty_r <= 1'h1;
        end
        else
        begin
            count_r <= count_nxt;
            full_r <= (count_nxt == DEPTH_C);
            empty_r <= (count_nxt == '0);
        end
    end

    a_fifo_no_overfill: assert property (@(posedge clk) disable iff (reset)
        full_r |=> count_r == DEPTH_C || $past(pop))
        else $error("fifo count moved past its depth");
endmodule

/* File: hw/sdsr_top.sv */
// dual 64-stage tapped shift register with tap snapshot fifo
`timescale 1ns/10ps

module sdsr_top
#(
    parameter int SNAP_DEPTH = sdsr_pkg::FIFO_DEPTH
)
(
    // system
    input wire logic clk,
    input wire logic reset,
    // channel a control and data
    input wire logic shift_clock_a,
    input wire logic serial_in_a,
    input wire logic split_mode_output_disable_a,
    // channel a taps, enables low while driving
    input wire logic tap_stage_16_a_in,
    output logic tap_stage_16_a_out,
    output logic tap_stage_16_a_oe_n,
    input wire logic tap_stage_32_a_in,
    output logic tap_stage_32_a_out,
    output logic tap_stage_32_a_oe_n,
    input wire logic tap_stage_48_a_in,
    output logic tap_stage_48_a_out,
    output logic tap_stage_48_a_oe_n,
    output logic tap_stage_64_a_out,
    output logic tap_stage_64_a_oe_n,
    // channel b control and data
    input wire logic shift_clock_b,
    input wire logic serial_in_b,
    input wire logic split_mode_output_disable_b,
    // channel b taps, enables low while driving
    input wire logic tap_stage_16_b_in,
    output logic tap_stage_16_b_out,
    output logic tap_stage_16_b_oe_n,
    input wire logic tap_stage_32_b_in,
    output logic tap_stage_32_b_out,
    output logic tap_stage_32_b_oe_n,
    input wire logic tap_stage_48_b_in,
    output logic tap_stage_48_b_out,
    output logic tap_stage_48_b_oe_n,
    output logic tap_stage_64_b_out,
    output logic tap_stage_64_b_oe_n,
    // tap snapshots taken after each shift, {b taps, a taps}
    output logic snap_valid,
    input wire logic snap_ready,
    output logic [7:0] snap_data,
    output logic snap_accept,
    output logic snap_overflow
);
    localparam int NC = sdsr_pkg::CHANNELS;
    localparam int NS = sdsr_pkg::STAGES;

    logic [NC-1:0] shift_clk_v;
    logic [NC-1:0] din_v;
    logic [NC-1:0] split_v;
    logic [NC-1:0] t16_in_v;
    logic [NC-1:0] t32_in_v;
    logic [NC-1:0] t48_in_v;
    logic [NC-1:0] rise_v;
    logic [NC-1:0] fall_v;
    logic [NS-1:0] stage_r [NC];
    logic [NS-1:0] stage_nxt [NC];
    logic oe_n_r [NC];
    logic snap_push_r;
    logic snap_overflow_r;
    logic fifo_in_ready;
    logic [7:0] snap_word;

    assign shift_clk_v = {shift_clock_b, shift_clock_a};
    assign din_v = {serial_in_b, serial_in_a};
    assign split_v = {split_mode_output_disable_b, split_mode_output_disable_a};
    assign t16_in_v = {tap_stage_16_b_in, tap_stage_16_a_in};
    assign t32_in_v = {tap_stage_32_b_in, tap_stage_32_a_in};
    assign t48_in_v = {tap_stage_48_b_in, tap_stage_48_a_in};

    // next chain contents for a rising edge in the given mode
    function automatic logic [NS-1:0] shift_next(input logic [NS-1:0] cur, input logic din,
        input logic split, input logic t16, input logic t32, input logic t48);
        logic [NS-1:0] n;
        n = {cur[NS-2:0], din};
        if (split)
        begin
            n[sdsr_pkg::LOAD17_POS] = t16;
            n[sdsr_pkg::LOAD33_POS] = t32;
            n[sdsr_pkg::LOAD49_POS] = t48;
        end
        return n;
    endfunction

    // one identical slice per channel with nothing shared between them
    for (genvar c = 0; c < NC; c++)
    begin : g_chan
        sdsr_edge_detect u_edge
        (
            .clk(clk),
            .reset(reset),
            .level_in(shift_clk_v[c]),
            .rise(rise_v[c]),
            .fall(fall_v[c])
        );

        assign stage_nxt[c] = shift_next(stage_r[c], din_v[c], split_v[c], t16_in_v[c], t32_in_v[c], t48_in_v[c]);

        // storage only moves on a rising edge, so a stopped clock holds it
        always_ff @(posedge clk)
        begin
            if (reset)
                stage_r[c] <= sdsr_pkg::STAGE_RESET;
            else if (rise_v[c])
                stage_r[c] <= stage_nxt[c];
        end

        // enables follow the control one cycle late; releasing early is not possible in a clocked pad
        always_ff @(posedge clk)
        begin
            if (reset)
                oe_n_r[c] <= sdsr_pkg::OE_N_RESET;
            else
                oe_n_r[c] <= split_v[c];
        end

        a_stage_one_load: assert property (@(posedge clk) disable iff (reset)
            rise_v[c] |=> stage_r[c][0] == $past(din_v[c]))
            else $error("stage one missed the serial input");

        a_serial_chain_shift: assert property (@(posedge clk) disable iff (reset)
            rise_v[c] && !split_v[c] |=> stage_r[c][NS-1:1] == $past(stage_r[c][NS-2:0]))
            else $error("single chain did not advance by one stage");

        a_split_tap_load: assert property (@(posedge clk) disable iff (reset)
            rise_v[c] && split_v[c] |=> stage_r[c][sdsr_pkg::LOAD17_POS] == $past(t16_in_v[c])
                && stage_r[c][sdsr_pkg::LOAD33_POS] == $past(t32_in_v[c])
                && stage_r[c][sdsr_pkg::LOAD49_POS] == $past(t48_in_v[c]))
            else $error("split segment heads did not load the taps");

        a_split_seg_shift: assert property (@(posedge clk) disable iff (reset)
            rise_v[c] && split_v[c] |=> stage_r[c][15:1] == $past(stage_r[c][14:0])
                && stage_r[c][63:49] == $past(stage_r[c][62:48]))
            else $error("split segment did not shift");

        a_taps_driven: assert property (@(posedge clk) disable iff (reset)
            !split_v[c] |=> !oe_n_r[c])
            else $error("taps not driven in single chain mode");

        a_taps_released: assert property (@(posedge clk) disable iff (reset)
            split_v[c] |=> oe_n_r[c])
            else $error("taps driven in split mode");

        a_static_hold: assert property (@(posedge clk) disable iff (reset)
            !rise_v[c] |=> stage_r[c] == $past(stage_r[c]))
            else $error("stages changed without a rising edge");

        a_fall_no_change: assert property (@(posedge clk) disable iff (reset)
            fall_v[c] ##1 !rise_v[c] [*2] |=> stage_r[c] == $past(stage_r[c], 3))
            else $error("falling edge disturbed the stages");

        // a clock held still for four samples must leave every stage alone
        sequence s_clock_stopped;
            !rise_v[c] [*4];
        endsequence

        // two single-chain shifts with the clock low in between
        sequence s_two_serial_shifts;
            (rise_v[c] && !split_v[c]) ##1 !rise_v[c] ##1 (rise_v[c] && !split_v[c]);
        endsequence

        a_stopped_hold: assert property (@(posedge clk) disable iff (reset)
            s_clock_stopped |=> stage_r[c] == $past(stage_r[c], 4))
            else $error("stopped clock disturbed the stages");

        a_two_shift_carry: assert property (@(posedge clk) disable iff (reset)
            s_two_serial_shifts |=> stage_r[c][NS-1:2] == $past(stage_r[c][NS-3:0], 3))
            else $error("two shifts did not move the chain two stages");

        a_split_mid_shift: assert property (@(posedge clk) disable iff (reset)
            rise_v[c] && split_v[c] |=> stage_r[c][31:17] == $past(stage_r[c][30:16])
                && stage_r[c][47:33] == $past(stage_r[c][46:32]))
            else $error("middle split segments did not shift");

        // segment heads must take the previous segment's tail, not the tap pins
        a_chain_boundary: assert property (@(posedge clk) disable iff (reset)
            rise_v[c] && !split_v[c] |=> stage_r[c][sdsr_pkg::LOAD17_POS] == $past(stage_r[c][sdsr_pkg::TAP16_POS])
                && stage_r[c][sdsr_pkg::LOAD33_POS] == $past(stage_r[c][sdsr_pkg::TAP32_POS])
                && stage_r[c][sdsr_pkg::LOAD49_POS] == $past(stage_r[c][sdsr_pkg::TAP48_POS]))
            else $error("segment boundaries broke the single chain");

        a_enable_follow: assert property (@(posedge clk) disable iff (reset)
            1'b1 |=> oe_n_r[c] == $past(split_v[c]))
            else $error("tap enables did not follow the control");
    end

    // taps are the stage flops themselves
    assign tap_stage_16_a_out = stage_r[0][sdsr_pkg::TAP16_POS];
    assign tap_stage_32_a_out = stage_r[0][sdsr_pkg::TAP32_POS];
    assign tap_stage_48_a_out = stage_r[0][sdsr_pkg::TAP48_POS];
    assign tap_stage_64_a_out = stage_r[0][sdsr_pkg::TAP64_POS];
    assign tap_stage_16_b_out = stage_r[1][sdsr_pkg::TAP16_POS];
    assign tap_stage_32_b_out = stage_r[1][sdsr_pkg::TAP32_POS];
    assign tap_stage_48_b_out = stage_r[1][sdsr_pkg::TAP48_POS];
    assign tap_stage_64_b_out = stage_r[1][sdsr_pkg::TAP64_POS];
    // the stage 64 pin has no input path at all, so split mode cannot load it
    assign tap_stage_16_a_oe_n = oe_n_r[0];
    assign tap_stage_32_a_oe_n = oe_n_r[0];
    assign tap_stage_48_a_oe_n = oe_n_r[0];
    assign tap_stage_64_a_oe_n = oe_n_r[0];
    assign tap_stage_16_b_oe_n = oe_n_r[1];
    assign tap_stage_32_b_oe_n = oe_n_r[1];
    assign tap_stage_48_b_oe_n = oe_n_r[1];
    assign tap_stage_64_b_oe_n = oe_n_r[1];

    a_tap_values: assert property (@(posedge clk) disable iff (reset)
        rise_v[0] && !split_v[0] |=> tap_stage_64_a_out == $past(stage_r[0][62])
            && tap_stage_16_a_out == $past(stage_r[0][14]))
        else $error("tap pins do not follow the chain");

    a_tap_values_b: assert property (@(posedge clk) disable iff (reset)
        rise_v[1] && !split_v[1] |=> tap_stage_32_b_out == $past(stage_r[1][30])
            && tap_stage_48_b_out == $past(stage_r[1][46]))
        else $error("channel b taps do not follow the chain");

    // the last stage pin must stay released in split mode on both channels
    a_tap64_release_a: assert property (@(posedge clk) disable iff (reset)
        split_v[0] |=> tap_stage_64_a_oe_n)
        else $error("stage 64 pin of channel a driven in split mode");

    a_tap64_release_b: assert property (@(posedge clk) disable iff (reset)
        split_v[1] |=> tap_stage_64_b_oe_n)
        else $error("stage 64 pin of channel b driven in split mode");

    // a shift on channel a alone must leave channel b's stages alone
    a_channel_apart: assert property (@(posedge clk) disable iff (reset)
        rise_v[0] && !rise_v[1] |=> stage_r[1] == $past(stage_r[1]))
        else $error("channel b moved on a channel a shift");

    // snapshot word taken one cycle after any shift, once the stages settled
    assign snap_word = {stage_r[1][sdsr_pkg::TAP64_POS], stage_r[1][sdsr_pkg::TAP48_POS],
        stage_r[1][sdsr_pkg::TAP32_POS], stage_r[1][sdsr_pkg::TAP16_POS],
        stage_r[0][sdsr_pkg::TAP64_POS], stage_r[0][sdsr_pkg::TAP48_POS],
        stage_r[0][sdsr_pkg::TAP32_POS], stage_r[0][sdsr_pkg::TAP16_POS]};

    always_ff @(posedge clk)
    begin
        if (reset)
            snap_push_r <= 1'h0;
        else
            snap_push_r <= |rise_v;
    end

    // shifting cannot wait, so a full fifo drops the snapshot and says so
    always_ff @(posedge clk)
    begin
        if (reset)
            snap_overflow_r <= 1'h0;
        else if (snap_push_r && !fifo_in_ready)
            snap_overflow_r <= 1'h1;
    end

    a_snap_push: assert property (@(posedge clk) disable iff (reset)
        |rise_v |=> snap_push_r)
        else $error("shift gave no snapshot request");

    a_overflow_set: assert property (@(posedge clk) disable iff (reset)
        snap_push_r && !fifo_in_ready |=> snap_overflow_r)
        else $error("dropped snapshot not flagged");

    a_overflow_sticky: assert property (@(posedge clk) disable iff (reset)
        snap_overflow_r |=> snap_overflow_r)
        else $error("overflow flag cleared without reset");

    sdsr_fifo
    #(
        .WIDTH(8),
        .DEPTH(SNAP_DEPTH)
    )
    u_snap_fifo
    (
        .clk(clk),
        .reset(reset),
        .in_valid(snap_push_r),
        .in_ready(fifo_in_ready),
        .in_data(snap_word),
        .out_valid(snap_valid),
        .out_ready(snap_ready),
        .out_data(snap_data)
    );

    assign snap_accept = fifo_in_ready;
    assign snap_overflow = snap_overflow_r;
endmodule

/* File: verif/sdsr_partner.sv */
// surrounding logic model that drives the three middle tap wires of one channel
`timescale 1ns/10ps
module sdsr_partner
(
    // system
    input wire logic clk,
    // design side of the taps
    input wire logic [2:0] tap_out,
    input wire logic [2:0] tap_oe_n,
    // bench commands
    input wire logic drive_en,
    input wire logic [2:0] drive_val,
    // resolved wire levels
    output logic [2:0] tap_wire
);
    logic [2:0] last_r;

    // an undriven wire shows the inverse of its last level, so a stale sample cannot pass
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (!tap_oe_n[i])
                tap_wire[i] = tap_out[i];
            else if (drive_en)
                tap_wire[i] = drive_val[i];
            else
                tap_wire[i] = ~last_r[i];
        end
    end

    always_ff @(posedge clk)
    begin
        last_r <= tap_wire;
    end
endmodule

/* File: verif/tb_dual_tapped_shift_register.sv */
// self-checking bench for the dual tapped shift register
`timescale 1ns/10ps
module tb_dual_tapped_shift_register;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [1:0] sck = 2'h0;
    logic [1:0] sin = 2'h0;
    logic [1:0] spl = 2'h0;
    logic [2:0] dv [2] = '{3'h0, 3'h0};
    logic pen = 1'b0;
    logic snap_ready = 1'b1;
    logic drop = 1'b0;
    wire [3:0] tout [2];
    wire [3:0] toe [2];
    wire [2:0] twire [2];
    wire snap_valid;
    wire snap_accept;
    wire snap_overflow;
    wire [7:0] snap_data;
    logic [63:0] st [2] = '{64'h0, 64'h0};
    logic [7:0] expq [$];
    int miscompares = 0;
    int tests_run = 0;

    always #20 clk = ~clk;

    for (genvar c = 0; c < 2; c++)
    begin : g_far
        sdsr_partner u_far
        (
            .clk(clk),
            .tap_out(tout[c][2:0]),
            .tap_oe_n(toe[c][2:0]),
            .drive_en(pen),
            .drive_val(dv[c]),
            .tap_wire(twire[c])
        );
    end

    sdsr_top u_dut
    (
        .clk(clk),
        .reset(reset),
        .shift_clock_a(sck[0]),
        .serial_in_a(sin[0]),
        .split_mode_output_disable_a(spl[0]),
        .tap_stage_16_a_in(twire[0][0]),
        .tap_stage_16_a_out(tout[0][0]),
        .tap_stage_16_a_oe_n(toe[0][0]),
        .tap_stage_32_a_in(twire[0][1]),
        .tap_stage_32_a_out(tout[0][1]),
        .tap_stage_32_a_oe_n(toe[0][1]),
        .tap_stage_48_a_in(twire[0][2]),
        .tap_stage_48_a_out(tout[0][2]),
        .tap_stage_48_a_oe_n(toe[0][2]),
        .tap_stage_64_a_out(tout[0][3]),
        .tap_stage_64_a_oe_n(toe[0][3]),
        .shift_clock_b(sck[1]),
        .serial_in_b(sin[1]),
        .split_mode_output_disable_b(spl[1]),
        .tap_stage_16_b_in(twire[1][0]),
        .tap_stage_16_b_out(tout[1][0]),
        .tap_stage_16_b_oe_n(toe[1][0]),
        .tap_stage_32_b_in(twire[1][1]),
        .tap_stage_32_b_out(tout[1][1]),
        .tap_stage_32_b_oe_n(toe[1][1]),
        .tap_stage_48_b_in(twire[1][2]),
        .tap_stage_48_b_out(tout[1][2]),
        .tap_stage_48_b_oe_n(toe[1][2]),
        .tap_stage_64_b_out(tout[1][3]),
        .tap_stage_64_b_oe_n(toe[1][3]),
        .snap_valid(snap_valid),
        .snap_ready(snap_ready),
        .snap_data(snap_data),
        .snap_accept(snap_accept),
        .snap_overflow(snap_overflow)
    );

    function automatic logic [3:0] tap(input logic [63:0] s);
        return {s[sdsr_pkg::TAP64_POS], s[sdsr_pkg::TAP48_POS], s[sdsr_pkg::TAP32_POS], s[sdsr_pkg::TAP16_POS]};
    endfunction

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        if (miscompares == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // control is set one edge ahead of the rise so the taps are already released when sampled
    task automatic shift(input logic [1:0] en, input logic [1:0] d, input logic [1:0] sp);
        logic [63:0] nx;
        spl = sp;
        sin = d;
        dv[0] = 3'($urandom);
        dv[1] = 3'($urandom);
        @(posedge clk);
        #1;
        sck = en;
        @(posedge clk);
        #1;
        sck = 2'h0;
        for (int c = 0; c < 2; c++)
        begin
            if (en[c])
            begin
                nx = {st[c][62:0], d[c]};
                if (sp[c])
                begin
                    nx[sdsr_pkg::LOAD17_POS] = dv[c][0];
                    nx[sdsr_pkg::LOAD33_POS] = dv[c][1];
                    nx[sdsr_pkg::LOAD49_POS] = dv[c][2];
                end
                st[c] = nx;
            end
        end
        if (!drop)
            expq.push_back({tap(st[1]), tap(st[0])});
        @(posedge clk);
        #1;
        for (int c = 0; c < 2; c++)
        begin
            check("taps", 64'(tout[c]), 64'(tap(st[c])));
            check("oe_n", 64'(toe[c]), 64'({4{sp[c]}}));
        end
    endtask

    // snapshot watcher: one queued note per popped word, looked at while it stands
    always @(negedge clk)
    begin
        if (reset === 1'b0 && snap_valid === 1'b1 && snap_ready === 1'b1)
        begin
            if (expq.size() == 0)
                check("snap_extra", 64'h1, 64'h0);
            else
                check("snap", 64'(snap_data), 64'(expq.pop_front()));
        end
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        miscompares++;
        finish_test();
    end

    initial
    begin
        void'($urandom(32'hd61d49a2));
        repeat (3) @(posedge clk);
        #1;
        reset = 1'b0;
        pen = 1'b1;
        check("oe_rst", 64'(toe[0]), 64'hf);
        check("accept_rst", 64'(snap_accept), 64'h1);
        repeat (140) shift(2'($urandom_range(1, 3)), 2'($urandom), 2'h0);
        repeat (80) shift(2'($urandom_range(1, 3)), 2'($urandom), 2'h3);
        repeat (60) shift(2'($urandom_range(1, 3)), 2'($urandom), 2'($urandom));
        // idle with the clock stopped: contents must hold
        repeat (6) @(posedge clk);
        #1;
        check("hold_a", 64'(tout[0]), 64'(tap(st[0])));
        check("hold_b", 64'(tout[1]), 64'(tap(st[1])));
        snap_ready = 1'b0;
        repeat (4) shift(2'h1, 2'($urandom), 2'h0);
        check("accept_full", 64'(snap_accept), 64'h0);
        drop = 1'b1;
        shift(2'h2, 2'($urandom), 2'h0);
        drop = 1'b0;
        @(posedge clk);
        #1;
        check("overflow", 64'(snap_overflow), 64'h1);
        snap_ready = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        check("drained", 64'(snap_valid), 64'h0);
        check("left", 64'(expq.size()), 64'h0);
        check("sticky", 64'(snap_overflow), 64'h1);
        reset = 1'b1;
        @(posedge clk);
        #1;
        reset = 1'b0;
        st[0] = 64'h0;
        st[1] = 64'h0;
        check("oe_rst2", 64'(toe[1]), 64'hf);
        check("ovf_rst", 64'(snap_overflow), 64'h0);
        repeat (8) shift(2'h3, 2'($urandom), 2'($urandom));
        repeat (4) @(posedge clk);
        #1;
        check("left_end", 64'(expq.size()), 64'h0);
        finish_test();
    end
endmodule
